//--- logic/inactivity_timer_pkg.sv
// constants, register map and carrier types of the inactivity timeout timer
// assumes a 100 mhz system clock and a 32-bit ahb-lite register bus
package inactivity_timer_pkg;
    // register indices, byte address is four times the index; index three reserved
    localparam logic [1:0] idx_timeout_period = 2'h0;
    localparam logic [1:0] idx_trigger_mask = 2'h1;
    localparam logic [1:0] idx_expiry_status = 2'h2;
    localparam logic [2:0] idx_irq_status = 3'h4;
    localparam logic [2:0] idx_irq_mask = 3'h5;
    localparam logic [2:0] idx_irq_route = 3'h6;
    localparam logic [7:0] reset_timeout_period = 8'h00;
    localparam logic [3:0] reset_trigger_mask = 4'h0;
    localparam logic [7:0] expiry_status_active = 8'h00;
    localparam logic [7:0] expiry_status_idle = 8'h01;
    localparam int num_sources = 4;
    // one minute in seconds, clock period in ns
    localparam longint minute_s = 60;
    localparam longint clk_period_ns = 10;
    localparam longint minute_cycles = minute_s * 1000000000 / clk_period_ns;
    // sticky event bits: 0 expiry, 1 trigger restart
    localparam int ev_expiry = 0;
    localparam int ev_restart = 1;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_count = 2'b01,
        st_expired = 2'b10
    } timer_state_t;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
    } ahb_req_t;
endpackage

//--- logic/inactivity_timeout_timer.sv
// inactivity timeout timer with ahb-lite register slave
// assumes irq request inputs synchronous to clk, single word transfers
//
// Function
// - eight-bit down counter decrements on each minute tick while active
// - reset clears period, idles timer, expiry high, all sources masked
// - nonzero period write activates timer and loads counter with value
// - unmasked trigger before zero reloads counter from period register
// - counter reaching zero stops, drives expiry low, status bit zero
// - any period write releases expiry high and sets status bit one
// - zero period write deactivates timer, expiry and management irq inactive
// - nonzero write while counting reloads new value immediately
// - assigned irq stays active while status bit reads low
// - period register is eight-bit readable writable minutes value
// - mask bits 3..0 enable second serial, first serial, mouse, keyboard
// - status bit mirrors expiry output level
// - registers decoded at offsets zero to two and four to six, offset three reserved
// - status reads 01h after reset and activation, upper bits zero
// - status shows internal expiry level, writes to status ignored
`timescale 1ns/100ps
module inactivity_timeout_timer #(
    parameter longint minute_ticks = inactivity_timer_pkg::minute_cycles
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // irq request lines: 3 second serial, 2 first serial, 1 mouse, 0 keyboard
    input wire logic [3:0] source_irq,
    // expiry and interrupt outputs
    output logic expiry_out_n,
    output logic system_management_irq,
    output logic irq
);

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    inactivity_timer_pkg::ahb_req_t req;
    logic wr_pend;
    logic [2:0] wr_idx;

    assign req = '{haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: hsize, hsel: hsel};
    wire take = req.hsel & hready & req.htrans[1];
    wire [2:0] rd_idx = req.haddr[4:2];
    wire addr_hi_ok = (req.haddr[31:5] == 27'h0);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend <= 1'b0;
            wr_idx <= 3'h0;
        end else begin
            wr_pend <= take & req.hwrite & addr_hi_ok;
            wr_idx <= rd_idx;
        end
    end

    // ------------------------------------------------------------
    // register write decode
    // ------------------------------------------------------------
    logic [7:0] timeout_period;
    logic [3:0] trigger_mask;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic irq_route;
    logic [7:0] count;
    logic [7:0] expiry_status;
    inactivity_timer_pkg::timer_state_t state;

    wire wr_period = wr_pend & (wr_idx == {1'b0, inactivity_timer_pkg::idx_timeout_period});
    wire wr_mask = wr_pend & (wr_idx == {1'b0, inactivity_timer_pkg::idx_trigger_mask});
    wire wr_istat = wr_pend & (wr_idx == inactivity_timer_pkg::idx_irq_status);
    wire wr_imask = wr_pend & (wr_idx == inactivity_timer_pkg::idx_irq_mask);
    wire wr_route = wr_pend & (wr_idx == inactivity_timer_pkg::idx_irq_route);
    wire [7:0] wdata = hwdata[7:0];

    // ------------------------------------------------------------
    // minute prescaler
    // ------------------------------------------------------------
    logic [39:0] presc;
    logic tick;
    wire presc_end = (presc == 40'(minute_ticks - 1));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            presc <= 40'h0;
            tick <= 1'b0;
        end else begin
            // restart the minute on any period write so a fresh load runs full minutes
            presc <= (presc_end | wr_period) ? 40'h0 : presc + 40'h1;
            tick <= presc_end & ~wr_period;
        end
    end

    // ------------------------------------------------------------
    // trigger detection and countdown
    // ------------------------------------------------------------
    wire trigger = |(source_irq & trigger_mask);
    wire counting = (state == inactivity_timer_pkg::st_count);
    wire reach_zero = counting & tick & ~trigger & ~wr_period & (count == 8'h01);
    wire restart = counting & trigger & ~wr_period;

    inactivity_timer_pkg::timer_state_t next_state;
    logic [7:0] next_count;

    always_comb begin
        next_state = state;
        next_count = count;
        if (wr_period) begin
            next_count = wdata;
            next_state = (wdata == 8'h00) ? inactivity_timer_pkg::st_idle
                                          : inactivity_timer_pkg::st_count;
        end else begin
            case (state)
                inactivity_timer_pkg::st_idle: begin
                    next_state = inactivity_timer_pkg::st_idle;
                end
                inactivity_timer_pkg::st_count: begin
                    if (trigger) begin
                        next_count = timeout_period;
                    end else if (tick) begin
                        next_count = count - 8'h01;
                        if (count == 8'h01) begin
                            next_state = inactivity_timer_pkg::st_expired;
                        end
                    end
                end
                inactivity_timer_pkg::st_expired: begin
                    next_state = inactivity_timer_pkg::st_expired;
                end
                default: begin
                    next_state = inactivity_timer_pkg::st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= inactivity_timer_pkg::st_idle;
            count <= 8'h00;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    wire [1:0] events = {restart, reach_zero};
    wire [1:0] clear_bits = wr_istat ? wdata[1:0] : 2'h0;
    wire [7:0] next_timeout_period = wr_period ? wdata : timeout_period;
    wire [3:0] next_trigger_mask = wr_mask ? wdata[3:0] : trigger_mask;
    wire [1:0] next_irq_mask = wr_imask ? wdata[1:0] : irq_mask;
    wire next_irq_route = wr_route ? wdata[0] : irq_route;
    // set wins over write-one-to-clear
    wire [1:0] next_irq_status = (irq_status & ~clear_bits) | events;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timeout_period <= inactivity_timer_pkg::reset_timeout_period;
            trigger_mask <= inactivity_timer_pkg::reset_trigger_mask;
            irq_mask <= 2'h0;
            irq_route <= 1'b0;
            irq_status <= 2'h0;
        end else begin
            timeout_period <= next_timeout_period;
            trigger_mask <= next_trigger_mask;
            irq_mask <= next_irq_mask;
            irq_route <= next_irq_route;
            irq_status <= next_irq_status;
        end
    end

    // ------------------------------------------------------------
    // expiry output, status and interrupts
    // ------------------------------------------------------------
    wire next_expired = (next_state == inactivity_timer_pkg::st_expired);
    wire [7:0] next_expiry_status = next_expired ? inactivity_timer_pkg::expiry_status_active
                                                 : inactivity_timer_pkg::expiry_status_idle;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            expiry_out_n <= 1'b1;
            expiry_status <= inactivity_timer_pkg::expiry_status_idle;
            system_management_irq <= 1'b0;
            irq <= 1'b0;
        end else begin
            expiry_out_n <= ~next_expired;
            expiry_status <= next_expiry_status;
            // route and expiry taken together so a route write never leaves a stale level
            system_management_irq <= next_irq_route & next_expired;
            irq <= |(next_irq_status & next_irq_mask);
        end
    end

    // ------------------------------------------------------------
    // read data and response
    // ------------------------------------------------------------
    // captured at the address phase from the values the registers take at that edge,
    // so a read right behind a write sees the new value
    wire rd_period = (rd_idx == {1'b0, inactivity_timer_pkg::idx_timeout_period});
    wire rd_mask = (rd_idx == {1'b0, inactivity_timer_pkg::idx_trigger_mask});
    wire rd_status = (rd_idx == {1'b0, inactivity_timer_pkg::idx_expiry_status});
    wire rd_istat = (rd_idx == inactivity_timer_pkg::idx_irq_status);
    wire rd_imask = (rd_idx == inactivity_timer_pkg::idx_irq_mask);
    wire rd_route = (rd_idx == inactivity_timer_pkg::idx_irq_route);
    wire [7:0] rd_val = !addr_hi_ok ? 8'h00
                      : rd_period ? next_timeout_period
                      : rd_mask ? {4'h0, next_trigger_mask}
                      : rd_status ? next_expiry_status
                      : rd_istat ? {6'h0, next_irq_status}
                      : rd_imask ? {6'h0, next_irq_mask}
                      : rd_route ? {7'h0, next_irq_route}
                      : 8'h00;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= {24'h0, rd_val};
            // zero wait states and an okay response on every transfer
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_period_write;
        wr_period;
    endsequence

    sequence s_released;
        expiry_out_n && (expiry_status == inactivity_timer_pkg::expiry_status_idle);
    endsequence

    sequence s_asserted;
        (state == inactivity_timer_pkg::st_expired) && !expiry_out_n
            && (expiry_status == inactivity_timer_pkg::expiry_status_active);
    endsequence

    property p_reload_on_trigger;
        @(posedge clk) disable iff (!nrst)
        (counting & trigger & ~wr_period) |=> (count == $past(timeout_period));
    endproperty
    a_reload_on_trigger: assert property (p_reload_on_trigger) else $error("no reload");

    property p_expire;
        @(posedge clk) disable iff (!nrst)
        reach_zero |=> s_asserted;
    endproperty
    a_expire: assert property (p_expire) else $error("expiry missed");

    property p_write_releases;
        @(posedge clk) disable iff (!nrst)
        s_period_write |=> s_released;
    endproperty
    a_write_releases: assert property (p_write_releases) else $error("expiry stuck low");

    property p_zero_idle;
        @(posedge clk) disable iff (!nrst)
        (wr_period & (wdata == 8'h00)) |=> (state == inactivity_timer_pkg::st_idle) ##1
            (expiry_out_n & !system_management_irq);
    endproperty
    a_zero_idle: assert property (p_zero_idle) else $error("zero write not idle");

    property p_load;
        @(posedge clk) disable iff (!nrst)
        (wr_period & (wdata != 8'h00)) |=> (count == $past(wdata)) && counting;
    endproperty
    a_load: assert property (p_load) else $error("load failed");

    property p_mirror;
        @(posedge clk) disable iff (!nrst)
        expiry_status == {7'h0, expiry_out_n};
    endproperty
    a_mirror: assert property (p_mirror) else $error("status not mirror");

    property p_irq_level;
        @(posedge clk) disable iff (!nrst)
        system_management_irq |-> (irq_route && expiry_status[0] == 1'b0);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq without expiry");

    property p_decrement;
        @(posedge clk) disable iff (!nrst)
        (counting & tick & ~trigger & ~wr_period) |=> (count == $past(count) - 8'h01);
    endproperty
    a_decrement: assert property (p_decrement) else $error("no decrement");

    property p_stop_at_zero;
        @(posedge clk) disable iff (!nrst)
        ((state == inactivity_timer_pkg::st_expired) & ~wr_period) |=>
            (state == inactivity_timer_pkg::st_expired) && (count == $past(count));
    endproperty
    a_stop_at_zero: assert property (p_stop_at_zero) else $error("count moved");

    property p_idle_quiet;
        @(posedge clk) disable iff (!nrst)
        (state == inactivity_timer_pkg::st_idle) |-> (expiry_out_n && !system_management_irq);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("idle not quiet");

    property p_upper_zero;
        @(posedge clk) disable iff (!nrst)
        (hrdata[31:8] == 24'h0) && (expiry_status[7:1] == 7'h0);
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

    property p_mask_gate;
        @(posedge clk) disable iff (!nrst)
        (counting & ~trigger & ~tick & ~wr_period) |=> counting && (count == $past(count));
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("masked source reloaded");

    property p_tick_phase;
        @(posedge clk) disable iff (!nrst)
        tick |-> (presc == 40'h0);
    endproperty
    a_tick_phase: assert property (p_tick_phase) else $error("tick off minute");

    property p_irq_active;
        @(posedge clk) disable iff (!nrst)
        (irq_route && (state == inactivity_timer_pkg::st_expired)) |-> system_management_irq;
    endproperty
    a_irq_active: assert property (p_irq_active) else $error("routed irq missing");

    property p_status_read;
        @(posedge clk) disable iff (!nrst)
        (take & ~req.hwrite & addr_hi_ok & rd_status) |=> (hrdata[0] == expiry_out_n);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

endmodule

//--- bench/irq_source_model.sv
// partner model: peripheral irq request lines seen by the timer
// assumes clk is the timer clock; control comes from the bench
`timescale 1ns/100ps
module irq_source_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control from the bench
    input wire logic [3:0] pulse_en,
    input wire logic [3:0] hold_on,
    // lines to the timer
    output logic [3:0] source_irq
);
    // ----------------------------------------
    // request generation
    // ----------------------------------------
    logic [3:0] phase;

    // one-cycle request every ten cycles on pulsed lines, level on held lines
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase <= 4'h0;
            source_irq <= 4'h0;
        end else begin
            phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
            source_irq <= hold_on | (pulse_en & {4{phase == 4'h0}});
        end
    end
endmodule

//--- bench/inactivity_timeout_timer_tb.sv
// self-checking bench of the inactivity timeout timer over ahb-lite
// assumes the irq source model beside it and a 20-cycle minute
`timescale 1ns/100ps
module inactivity_timeout_timer_tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam longint tick = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, expiry_out_n, system_management_irq, irq;
    logic [3:0] source_irq;
    logic [3:0] pulse_en = 4'h0;
    logic [3:0] hold_on = 4'h0;
    int errors = 0;
    int n_checks = 0;

    always #5 clk = ~clk;

    inactivity_timeout_timer #(.minute_ticks(tick)) i_dut (
        .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .source_irq(source_irq), .expiry_out_n(expiry_out_n),
        .system_management_irq(system_management_irq), .irq(irq)
    );
    irq_source_model i_src (
        .clk(clk), .nrst(nrst), .pulse_en(pulse_en), .hold_on(hold_on),
        .source_irq(source_irq)
    );

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        n = 0;
        do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
        r = hrdata;
        chk("hready", 32'h1, {31'h0, hreadyout});
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, {24'h0, d}, r);
    endtask

    task automatic rd(input logic [31:0] a, input logic [7:0] e);
        logic [31:0] r;
        xfer(a, 1'b0, 32'h0, r);
        chk("read data", {24'h0, e}, r);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    // expiry, management irq and irq, sampled mid-cycle
    task automatic outs(input logic [2:0] e);
        cyc(2);
        @(negedge clk);
        chk("outputs", {29'h0, e}, {29'h0, expiry_out_n, system_management_irq, irq});
        @(posedge clk);
    endtask

    task automatic wait_low(input int b);
        int n;
        n = 0;
        do @(negedge clk); while (expiry_out_n !== 1'b0 && ++n < b);
        chk("expiry", 32'h0, {31'h0, expiry_out_n});
        @(posedge clk);
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        #200000;
        errors++;
        print_verdict();
    end

    initial begin
        cyc(10);
        nrst <= 1'b1;
        cyc(1);
        outs(3'b100);
        rd(32'h00, 8'h00);
        rd(32'h04, 8'h00);
        rd(32'h08, 8'h01);
        wr(32'h04, 8'hff);
        rd(32'h04, 8'h0f);
        wr(32'h08, 8'h00);
        rd(32'h08, 8'h01);
        wr(32'h0c, 8'hff);
        rd(32'h0c, 8'h00);
        wr(32'h04, 8'h00);
        wr(32'h00, 8'ha5);
        rd(32'h00, 8'ha5);
        rd(32'h08, 8'h01);
        wr(32'h00, 8'h02);
        cyc(30);
        outs(3'b100);
        wait_low(30);
        rd(32'h08, 8'h00);
        rd(32'h10, 8'h01);
        wr(32'h18, 8'h01);
        outs(3'b010);
        wr(32'h14, 8'h01);
        outs(3'b011);
        wr(32'h10, 8'h01);
        outs(3'b010);
        wr(32'h00, 8'h00);
        cyc(60);
        outs(3'b100);
        rd(32'h08, 8'h01);
        wr(32'h00, 8'h03);
        cyc(45);
        wr(32'h00, 8'h03);
        cyc(35);
        outs(3'b100);
        wait_low(40);
        wr(32'h18, 8'h00);
        wr(32'h14, 8'h00);
        for (int i = 0; i < 4; i++) begin
            pulse_en <= 4'h1 << i;
            hold_on <= ~(4'h1 << i);
            wr(32'h04, 8'h01 << i);
            wr(32'h00, 8'h02);
            cyc(80);
            outs(3'b100);
            pulse_en <= 4'h0;
            wait_low(60);
        end
        print_verdict();
    end
endmodule
